// ### rtl/uhtx_regs.svh
`ifndef UHTX_REGS_SVH
`define UHTX_REGS_SVH

// Register bus address width
`define UHTX_ADDR_W 10

// Control-high register offsets, one per transmit endpoint
`define UHTX_OFS_EP1 10'h113
`define UHTX_OFS_EP2 10'h123
`define UHTX_OFS_EP3 10'h133
`define UHTX_OFS_STEP 10'h010

// Reset value of the whole register
`define UHTX_RESET 8'h00

// Field positions
`define UHTX_BIT_AUTO 7
`define UHTX_BIT_RSVD 6
`define UHTX_BIT_DIR 5
`define UHTX_BIT_DMA_REQUEST_ENABLE 4
`define UHTX_BIT_FORCE 3
`define UHTX_BIT_DMA_REQUEST_MODE 2
`define UHTX_BIT_TOGGLE_WRITE_ENABLE 1
`define UHTX_BIT_DT 0

// Endpoint count and max packet size field width
`define UHTX_NUM_EP 3
`define UHTX_MPS_W 11

`endif

// ### rtl/uhtx_pkg.sv
package uhtx_pkg;

    // One register byte
    typedef logic [7:0] uhtx_byte_t;

    // When a DMA-driven endpoint raises its interrupt
    typedef enum logic {
        UHTX_IRQ_PER_PKT,
        UHTX_IRQ_PER_XFER
    } uhtx_dma_mode_t;

endpackage

// ### rtl/uhtx_fill.sv
`timescale 1ns/1ps

// Counts bytes loaded into one endpoint FIFO and flags a max-size packet
module uhtx_fill #(
    parameter int MPS_W = 11
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic load,
    input wire logic clear,
    input wire logic [MPS_W-1:0] max_size,
    output logic full
);
    logic [MPS_W-1:0] count_q;

    initial begin
        if (MPS_W < 1 || MPS_W > 16) begin
            $error("uhtx_fill: MPS_W out of range");
        end
    end

    // Full only for a non-zero size; a zero size never auto-completes
    assign full = (max_size != '0) && (count_q == max_size);

    // Saturates at a non-zero max size so a missed auto set does not wrap
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count_q <= '0;
        end else if (clear) begin
            count_q <= '0;
        end else if (load && !full) begin
            count_q <= count_q + 1'b1;
        end
    end

endmodule

// ### rtl/uhtx_ctrl.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "uhtx_regs.svh"

// Overview of operation
// R1: Auto set raises packet ready once a max-size packet sits in the FIFO.
// R2: Bit 6 is reserved, read-only, reads zero.
// R3: Direction bit: 0 selects receive, 1 selects transmit.
// R4: Direction bit acts only on a shared FIFO endpoint.
// R5: DMA enable bit gates every DMA request of the endpoint.
// R6: Software also programs the DMA channel select when enabling DMA.
// R7: Writing force toggle flips the toggle and flushes the current packet.
// R8: DMA mode 0 interrupts per packet, 1 per whole transfer.
// R9: Software clears DMA mode only after clearing DMA enable.
// R10: Toggle write enable gates writes to the data toggle.
// R11: Toggle write enable self-clears once a toggle value is written.
// R12: Bit 0 reads the current data toggle.
// R13: With write enable low, written toggle values are ignored.
// R14: Software changes the toggle directly only when resetting the endpoint.
// R15: Endpoint 1 register sits at 0x113 and resets to 0x00.
// R16: Software sets packet ready; hardware clears it once the packet is sent.
// R17: Same 8-bit layout repeats for endpoints 2 and 3 at 0x123, 0x133.
// R18: Each acknowledged transmitted packet flips the data toggle.
module uhtx_ctrl #(
    parameter int NUM_EP = `UHTX_NUM_EP,
    parameter int MPS_W = `UHTX_MPS_W
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [`UHTX_ADDR_W-1:0] reg_addr,
    input wire uhtx_pkg::uhtx_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output uhtx_pkg::uhtx_byte_t reg_rdata,
    input wire logic [NUM_EP-1:0] fifo_shared,
    input wire logic [NUM_EP-1:0][MPS_W-1:0] tx_max_packet_size,
    input wire logic [NUM_EP-1:0] fifo_load,
    input wire logic [NUM_EP-1:0] sw_set_ready,
    input wire logic [NUM_EP-1:0] pkt_sent,
    input wire logic [NUM_EP-1:0] pkt_acked,
    input wire logic [NUM_EP-1:0] dma_pkt_done,
    input wire logic [NUM_EP-1:0] dma_xfer_done,
    output logic [NUM_EP-1:0] packet_ready_flag,
    output logic [NUM_EP-1:0] ep_dir_tx,
    output logic [NUM_EP-1:0] dma_req,
    output logic [NUM_EP-1:0] dma_irq,
    output logic [NUM_EP-1:0] fifo_flush,
    output logic [NUM_EP-1:0] data_toggle_state
);
    import uhtx_pkg::*;

    // Per-endpoint register fields
    logic [NUM_EP-1:0] auto_q;
    logic [NUM_EP-1:0] dir_q;
    logic [NUM_EP-1:0] dma_request_enable_q;
    uhtx_dma_mode_t dma_request_mode_q [NUM_EP];
    logic [NUM_EP-1:0] toggle_write_enable_q;
    logic [NUM_EP-1:0] dt_q;
    logic [NUM_EP-1:0] rdy_q;
    logic [NUM_EP-1:0] flush_q;
    logic [NUM_EP-1:0] irq_q;

    // Decode and event terms
    logic [NUM_EP-1:0] hit;
    logic [NUM_EP-1:0] wr_hit;
    logic [NUM_EP-1:0] force_wr;
    logic [NUM_EP-1:0] dt_wr;
    logic [NUM_EP-1:0] acked_sent;
    logic [NUM_EP-1:0] fill_full;
    logic [NUM_EP-1:0] auto_set;
    logic [NUM_EP-1:0] set_rdy;
    uhtx_byte_t view [NUM_EP];
    uhtx_byte_t rdata_d;
    uhtx_byte_t rdata_q;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // Only three register slots exist in the map
    initial begin
        if (NUM_EP < 1 || NUM_EP > 3) begin
            $error("uhtx_ctrl: NUM_EP must be 1 to 3");
        end
        if (MPS_W < 1 || MPS_W > 16) begin
            $error("uhtx_ctrl: MPS_W out of range");
        end
    end

    genvar i;
    generate
        for (i = 0; i < NUM_EP; i++) begin : g_ep
            // Slots are spaced one step apart from endpoint 1
            assign hit[i] = (reg_addr ==
                `UHTX_OFS_EP1 + 10'(i) * `UHTX_OFS_STEP); // [R15] [R17]
            assign wr_hit[i] = reg_wr && hit[i];
            assign force_wr[i] = wr_hit[i] && reg_wdata[`UHTX_BIT_FORCE]; // [R7]
            // Toggle write takes effect only with the stored enable set
            assign dt_wr[i] = wr_hit[i] && toggle_write_enable_q[i]; // [R10] [R13]
            assign acked_sent[i] = pkt_sent[i] && pkt_acked[i];
            assign auto_set[i] = auto_q[i] && fill_full[i]; // [R1]
            assign set_rdy[i] = sw_set_ready[i] || auto_set[i]; // [R16]

            // Byte counter feeding the auto set
            uhtx_fill #(
                .MPS_W(MPS_W)
            ) u_fill (
                .clk_sys(clk_sys),
                .rst(rst),
                .load(fifo_load[i]),
                .clear(set_rdy[i] || force_wr[i]),
                .max_size(tx_max_packet_size[i]),
                .full(fill_full[i])
            );

            // Plain read/write control fields
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    auto_q[i] <= 1'b0;
                    dir_q[i] <= 1'b0;
                    dma_request_enable_q[i] <= 1'b0;
                    dma_request_mode_q[i] <= UHTX_IRQ_PER_PKT;
                end else if (wr_hit[i]) begin
                    auto_q[i] <= reg_wdata[`UHTX_BIT_AUTO];
                    dir_q[i] <= reg_wdata[`UHTX_BIT_DIR];
                    dma_request_enable_q[i] <= reg_wdata[`UHTX_BIT_DMA_REQUEST_ENABLE];
                    dma_request_mode_q[i] <= uhtx_dma_mode_t'(reg_wdata[`UHTX_BIT_DMA_REQUEST_MODE]);
                end
            end

            // Write enable drops after the toggle write it unlocked
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    toggle_write_enable_q[i] <= 1'b0;
                end else if (dt_wr[i]) begin
                    toggle_write_enable_q[i] <= 1'b0; // [R11]
                end else if (wr_hit[i]) begin
                    toggle_write_enable_q[i] <= reg_wdata[`UHTX_BIT_TOGGLE_WRITE_ENABLE];
                end
            end

            // Software load wins; otherwise force and ACK flips combine
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    dt_q[i] <= 1'b0;
                end else if (dt_wr[i]) begin
                    dt_q[i] <= reg_wdata[`UHTX_BIT_DT]; // [R10]
                end else begin
                    dt_q[i] <= dt_q[i] ^ force_wr[i] ^ acked_sent[i]; // [R7] [R18]
                end
            end

            // Set wins over clear so a set in a send cycle is kept
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    rdy_q[i] <= 1'b0;
                end else if (set_rdy[i]) begin
                    rdy_q[i] <= 1'b1; // [R1] [R16]
                end else if (pkt_sent[i] || force_wr[i]) begin
                    rdy_q[i] <= 1'b0; // [R16] [R7]
                end
            end

            // Flush pulse to the FIFO and mode-selected DMA interrupt
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    flush_q[i] <= 1'b0;
                    irq_q[i] <= 1'b0;
                end else begin
                    flush_q[i] <= force_wr[i]; // [R7]
                    if (!dma_request_enable_q[i]) begin
                        irq_q[i] <= 1'b0;
                    end else if (dma_request_mode_q[i] == UHTX_IRQ_PER_XFER) begin
                        irq_q[i] <= dma_xfer_done[i]; // [R8]
                    end else begin
                        irq_q[i] <= dma_pkt_done[i]; // [R8]
                    end
                end
            end

            // Register image; force bit is write-only and reads zero
            always_comb begin
                view[i] = `UHTX_RESET;
                view[i][`UHTX_BIT_AUTO] = auto_q[i];
                view[i][`UHTX_BIT_RSVD] = 1'b0; // [R2]
                view[i][`UHTX_BIT_DIR] = dir_q[i];
                view[i][`UHTX_BIT_DMA_REQUEST_ENABLE] = dma_request_enable_q[i];
                view[i][`UHTX_BIT_DMA_REQUEST_MODE] = dma_request_mode_q[i];
                view[i][`UHTX_BIT_TOGGLE_WRITE_ENABLE] = toggle_write_enable_q[i];
                view[i][`UHTX_BIT_DT] = dt_q[i]; // [R12]
            end

            // A dedicated TX endpoint ignores the direction bit
            assign ep_dir_tx[i] = fifo_shared[i] ? dir_q[i] : 1'b1; // [R3] [R4]
            // Ask for data only while enabled, facing TX and not yet ready
            assign dma_req[i] = dma_request_enable_q[i] && ep_dir_tx[i] && !rdy_q[i]; // [R5]

            property p_auto_set;
                auto_q[i] && fill_full[i] |=> rdy_q[i];
            endproperty
            a_auto_set: assert property (p_auto_set) // [R1]
                else $error("auto set did not raise packet ready");

            property p_dir;
                fifo_shared[i] |-> ep_dir_tx[i] == dir_q[i];
            endproperty
            a_dir: assert property (p_dir) // [R3]
                else $error("shared endpoint direction wrong");

            property p_dir_fixed;
                !fifo_shared[i] |-> ep_dir_tx[i];
            endproperty
            a_dir_fixed: assert property (p_dir_fixed) // [R4]
                else $error("dedicated endpoint not transmit");

            property p_dma_off;
                !dma_request_enable_q[i] |-> !dma_req[i] ##1 !dma_irq[i];
            endproperty
            a_dma_off: assert property (p_dma_off) // [R5]
                else $error("DMA activity while disabled");

            property p_force;
                force_wr[i] && !dt_wr[i] && !acked_sent[i] && !set_rdy[i] |=>
                    fifo_flush[i] && !packet_ready_flag[i] &&
                    data_toggle_state[i] != $past(dt_q[i]);
            endproperty
            a_force: assert property (p_force) // [R7]
                else $error("force toggle did not flip and flush");

            property p_irq_xfer;
                dma_request_enable_q[i] && dma_request_mode_q[i] == UHTX_IRQ_PER_XFER &&
                    !dma_xfer_done[i] |=> !dma_irq[i];
            endproperty
            a_irq_xfer: assert property (p_irq_xfer) // [R8]
                else $error("per-transfer mode raised early interrupt");

            property p_irq_pkt;
                dma_request_enable_q[i] && dma_request_mode_q[i] == UHTX_IRQ_PER_PKT &&
                    dma_pkt_done[i] |=> dma_irq[i];
            endproperty
            a_irq_pkt: assert property (p_irq_pkt) // [R8]
                else $error("per-packet interrupt missing");

            property p_dt_load;
                dt_wr[i] |=> dt_q[i] == $past(reg_wdata[`UHTX_BIT_DT]) && !toggle_write_enable_q[i];
            endproperty
            a_dt_load: assert property (p_dt_load) // [R10] [R11]
                else $error("enabled toggle write not applied");

            property p_dt_ignore;
                wr_hit[i] && !toggle_write_enable_q[i] && !reg_wdata[`UHTX_BIT_FORCE] &&
                    !acked_sent[i] |=> $stable(dt_q[i]);
            endproperty
            a_dt_ignore: assert property (p_dt_ignore) // [R13]
                else $error("toggle changed without write enable");

            property p_sent_clr;
                pkt_sent[i] && !set_rdy[i] |=> !packet_ready_flag[i];
            endproperty
            a_sent_clr: assert property (p_sent_clr) // [R16]
                else $error("packet ready not cleared after send");

            property p_ack_flip;
                acked_sent[i] && !dt_wr[i] && !force_wr[i] |=>
                    dt_q[i] != $past(dt_q[i]);
            endproperty
            a_ack_flip: assert property (p_ack_flip) // [R18]
                else $error("acknowledged packet did not flip toggle");

            c_auto: cover property (auto_q[i] && fill_full[i] ##1 pkt_sent[i]);
            c_force: cover property (force_wr[i] ##1 fifo_flush[i]);
            c_dt_write: cover property (wr_hit[i] && reg_wdata[`UHTX_BIT_TOGGLE_WRITE_ENABLE] ##[1:4] dt_wr[i]);
        end
    endgenerate

    // Read mux; unmapped addresses answer zero
    always_comb begin
        rdata_d = `UHTX_RESET;
        for (int k = 0; k < NUM_EP; k++) begin
            if (hit[k]) begin
                rdata_d = view[k];
            end
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_q <= `UHTX_RESET;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= `UHTX_RESET;
        end
    end

    property p_rsvd;
        reg_rd |=> !reg_rdata[`UHTX_BIT_RSVD] && !reg_rdata[`UHTX_BIT_FORCE];
    endproperty
    a_rsvd: assert property (p_rsvd) // [R2]
        else $error("reserved or force bit read as one");

    property p_read_dt;
        reg_rd && hit[0] |=> reg_rdata[`UHTX_BIT_DT] == $past(dt_q[0]);
    endproperty
    a_read_dt: assert property (p_read_dt) // [R12]
        else $error("read toggle does not match state");

    property p_read_once;
        !reg_rd |=> reg_rdata == `UHTX_RESET;
    endproperty
    a_read_once: assert property (p_read_once) // [R15]
        else $error("read data outside its cycle");

    assign reg_rdata = rdata_q;
    assign packet_ready_flag = rdy_q;
    assign fifo_flush = flush_q;
    assign dma_irq = irq_q;
    assign data_toggle_state = dt_q;

endmodule

// ### dv/uhtx_far_model.sv
`timescale 1ns/1ps

// Far side: packet engine with its peripheral, plus the DMA controller
module uhtx_far_model #(
    parameter int NUM_EP = 3
) (
    input wire logic clk_sys,
    input wire logic rst,
    output logic [NUM_EP-1:0] pkt_sent,
    output logic [NUM_EP-1:0] pkt_acked,
    output logic [NUM_EP-1:0] dma_pkt_done,
    output logic [NUM_EP-1:0] dma_xfer_done
);
    logic [NUM_EP-1:0] ack_q = '0;
    logic [NUM_EP-1:0] busy_q = '0;
    logic noise_q = 1'b0;

    // Ack means nothing outside a send; keep it moving so a stale value never passes
    always @(posedge clk_sys or posedge rst) begin
        noise_q <= rst ? 1'b0 : ~noise_q;
    end
    assign pkt_acked = (busy_q & ack_q) | (~busy_q & {NUM_EP{noise_q}});

    initial begin
        pkt_sent = '0;
        dma_pkt_done = '0;
        dma_xfer_done = '0;
    end

    // Peripheral answers after a number of idle cycles, prompt or slow
    task automatic send(input int ep, input bit ack, input int delay);
        repeat (delay) @(posedge clk_sys);
        @(posedge clk_sys);
        pkt_sent[ep] <= 1'b1;
        busy_q[ep] <= 1'b1;
        ack_q[ep] <= ack;
        @(posedge clk_sys);
        pkt_sent[ep] <= 1'b0;
        busy_q[ep] <= 1'b0;
    endtask

    // One DMA event: a single packet moved, or the whole transfer done
    task automatic dma(input int ep, input bit whole);
        @(posedge clk_sys);
        dma_pkt_done[ep] <= ~whole;
        dma_xfer_done[ep] <= whole;
        @(posedge clk_sys);
        dma_pkt_done[ep] <= 1'b0;
        dma_xfer_done[ep] <= 1'b0;
    endtask
endmodule

// ### dv/tb_usb_host_tx_endpoint_ctrl_high.sv
`timescale 1ns/1ps
`include "uhtx_regs.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end

module tb_usb_host_tx_endpoint_ctrl_high;
    import uhtx_pkg::*;
    logic clk_sys, rst, reg_wr, reg_rd;
    logic [`UHTX_ADDR_W-1:0] reg_addr;
    uhtx_byte_t reg_wdata, reg_rdata, rv;
    logic [2:0] fifo_shared, fifo_load, sw_set_ready, pkt_sent, pkt_acked;
    logic [2:0] dma_pkt_done, dma_xfer_done, packet_ready_flag, ep_dir_tx;
    logic [2:0] dma_req, dma_irq, fifo_flush, data_toggle_state;
    logic [2:0][10:0] tx_max_packet_size;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;

    uhtx_ctrl uhtx_ctrl_i (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .fifo_shared(fifo_shared), .tx_max_packet_size(tx_max_packet_size),
        .fifo_load(fifo_load), .sw_set_ready(sw_set_ready), .pkt_sent(pkt_sent),
        .pkt_acked(pkt_acked), .dma_pkt_done(dma_pkt_done), .dma_xfer_done(dma_xfer_done),
        .packet_ready_flag(packet_ready_flag), .ep_dir_tx(ep_dir_tx), .dma_req(dma_req),
        .dma_irq(dma_irq), .fifo_flush(fifo_flush), .data_toggle_state(data_toggle_state));

    uhtx_far_model uhtx_far_model_i (.clk_sys(clk_sys), .rst(rst), .pkt_sent(pkt_sent),
        .pkt_acked(pkt_acked), .dma_pkt_done(dma_pkt_done), .dma_xfer_done(dma_xfer_done));

    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Hang guard; the whole run needs about a hundred cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            finish_test();
        end
    end

    task finish_test;
        if (error_cnt == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task wr(input logic [9:0] a, input uhtx_byte_t d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task rd(input logic [9:0] a, output uhtx_byte_t d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Software packet-ready set on endpoint 1
    task set_ready;
        @(posedge clk_sys);
        sw_set_ready[0] <= 1'b1;
        @(posedge clk_sys);
        sw_set_ready[0] <= 1'b0;
        #1;
    endtask

    // Load n bytes into endpoint 1 back to back
    task load(input int n);
        @(posedge clk_sys);
        fifo_load[0] <= 1'b1;
        repeat (n - 1) @(posedge clk_sys);
        @(posedge clk_sys);
        fifo_load[0] <= 1'b0;
        #1;
    endtask

    task t_reset;
        rd(`UHTX_OFS_EP1, rv); `CHK("ep1 reset", 8'h00, rv)
        rd(`UHTX_OFS_EP2, rv); `CHK("ep2 reset", 8'h00, rv)
        rd(`UHTX_OFS_EP3, rv); `CHK("ep3 reset", 8'h00, rv)
        wr(10'h114, 8'h20);
        rd(10'h114, rv); `CHK("unmapped", 8'h00, rv)
        `CHK("ep1 dir", 1'b0, ep_dir_tx[0])
    endtask

    task t_fields;
        wr(`UHTX_OFS_EP1, 8'he4);
        rd(`UHTX_OFS_EP1, rv); `CHK("reserved", 8'ha4, rv)
        `CHK("dir tx", 1'b1, ep_dir_tx[0])
        wr(`UHTX_OFS_EP1, 8'h00); `CHK("dir rx", 1'b0, ep_dir_tx[0])
        wr(`UHTX_OFS_EP2, 8'h10); `CHK("dedicated", 1'b1, ep_dir_tx[1])
        rd(`UHTX_OFS_EP2, rv); `CHK("ep2 reg", 8'h10, rv)
        wr(`UHTX_OFS_EP3, 8'h20);
        rd(`UHTX_OFS_EP3, rv); `CHK("ep3 reg", 8'h20, rv)
        `CHK("ep3 dir", 1'b1, ep_dir_tx[2])
    endtask

    // Direct toggle writes, as done when the endpoint is reset
    task t_toggle;
        wr(`UHTX_OFS_EP1, 8'h01); `CHK("dt locked", 1'b0, data_toggle_state[0])
        wr(`UHTX_OFS_EP1, 8'h02);
        rd(`UHTX_OFS_EP1, rv); `CHK("toggle_write_enable", 8'h02, rv)
        wr(`UHTX_OFS_EP1, 8'h01); `CHK("dt write", 1'b1, data_toggle_state[0])
        rd(`UHTX_OFS_EP1, rv); `CHK("toggle_write_enable clear", 8'h01, rv)
        wr(`UHTX_OFS_EP1, 8'h00); `CHK("dt kept", 1'b1, data_toggle_state[0])
    endtask

    task t_force;
        set_ready(); `CHK("ready", 1'b1, packet_ready_flag[0])
        wr(`UHTX_OFS_EP1, 8'h08); `CHK("flush", 1'b1, fifo_flush[0])
        `CHK("force dt", 1'b0, data_toggle_state[0])
        `CHK("force ready", 1'b0, packet_ready_flag[0])
        @(posedge clk_sys);
        #1; `CHK("flush end", 1'b0, fifo_flush[0])
        rd(`UHTX_OFS_EP1, rv); `CHK("force read", 8'h00, rv)
    endtask

    // Channel select is assumed programmed by software with the enable
    task t_dma;
        wr(`UHTX_OFS_EP1, 8'h30); `CHK("dma req", 1'b1, dma_req[0])
        uhtx_far_model_i.dma(0, 1'b0);
        #1; `CHK("irq pkt", 1'b1, dma_irq[0])
        uhtx_far_model_i.dma(0, 1'b1);
        #1; `CHK("no irq xfer", 1'b0, dma_irq[0])
        wr(`UHTX_OFS_EP1, 8'h34);
        uhtx_far_model_i.dma(0, 1'b1);
        #1; `CHK("irq xfer", 1'b1, dma_irq[0])
        uhtx_far_model_i.dma(0, 1'b0);
        #1; `CHK("no irq pkt", 1'b0, dma_irq[0])
        wr(`UHTX_OFS_EP1, 8'h24); `CHK("dma off", 1'b0, dma_req[0])
        uhtx_far_model_i.dma(0, 1'b1);
        #1; `CHK("irq off", 1'b0, dma_irq[0])
        wr(`UHTX_OFS_EP1, 8'h20);
    endtask

    task t_auto;
        wr(`UHTX_OFS_EP1, 8'ha0);
        load(2); `CHK("auto early", 1'b0, packet_ready_flag[0])
        @(posedge clk_sys);
        #1; `CHK("auto set", 1'b1, packet_ready_flag[0])
        uhtx_far_model_i.send(0, 1'b1, 3);
        #1; `CHK("sent clr", 1'b0, packet_ready_flag[0])
        `CHK("ack flip", 1'b1, data_toggle_state[0])
        load(1);
        repeat (3) @(posedge clk_sys);
        #1; `CHK("short", 1'b0, packet_ready_flag[0])
        set_ready(); `CHK("manual", 1'b1, packet_ready_flag[0])
        uhtx_far_model_i.send(0, 1'b0, 0);
        #1; `CHK("nak clr", 1'b0, packet_ready_flag[0])
        `CHK("nak keep", 1'b1, data_toggle_state[0])
        wr(`UHTX_OFS_EP1, 8'h20);
        load(2);
        repeat (2) @(posedge clk_sys);
        #1; `CHK("auto off", 1'b0, packet_ready_flag[0])
    endtask

    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        fifo_shared = 3'b101;
        fifo_load = '0;
        sw_set_ready = '0;
        tx_max_packet_size = {11'd4, 11'd4, 11'd2};
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_fields();
        t_toggle();
        t_force();
        t_dma();
        t_auto();
        finish_test();
    end
endmodule
